// ==== core/ccpm_core.sv ====
// Clock selection, core clock division, low-frequency source and power-mode control.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`include "ccpm_map.svh"
module ccpm_core (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire ccpm_pkg::ccpm_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    // Oscillator and low-frequency clock status from the analog side
    input wire logic fast_xo_running,
    input wire logic low_freq_clock,
    input wire logic low_freq_ready,
    // Wakeup events, one-cycle pulses on clk_sys
    input wire ccpm_pkg::ccpm_wake_t wake_event,
    // Clock and power controls
    output ccpm_pkg::ccpm_clk_ctl_t clk_ctl,
    output logic [2:0] power_mode,
    output logic mcu_hold,
    output logic crystal_ready_interrupt,
    output logic crystal_ready_wakeup
);
    import ccpm_pkg::*;

    ccpm_state_rec_t s;
    ccpm_state_rec_t next_s;

    logic xo_run;
    logic lf_level;
    logic lf_rdy;
    logic wake_any;
    logic lf_active;
    logic pd_reserved;

    // ----------------------------------------------------------------
    // Synchronised inputs
    // ----------------------------------------------------------------
    // The status lines come from other clocks; crystal status changes once stages two and three agree, ready needs both set, the level is stage three alone.
    always_comb begin
        xo_run = (s.xo_sync[1] == s.xo_sync[2]) ? s.xo_sync[2] : s.xo_seen;
        lf_level = s.lf_sync[2];
        lf_rdy = s.lfr_sync[2] & s.lfr_sync[1];
        wake_any = wake_event.pin | wake_event.tick | wake_event.comp;
        lf_active = (s.lf_src != `CCPM_LF_NONE) && lf_rdy;
        pd_reserved = (bus_req.wdata[2:0] == 3'h5) || (bus_req.wdata[2:0] == 3'h6);
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.xo_sync = {s.xo_sync[1:0], fast_xo_running};
        next_s.lf_sync = {s.lf_sync[1:0], low_freq_clock};
        next_s.lfr_sync = {s.lfr_sync[1:0], low_freq_ready};
        next_s.xo_seen = xo_run;
        next_s.xrdy_irq = xo_run && !s.xo_seen && s.core_ctl[`CCPM_CC_XRDY_EN]; // see [RULE5]
        next_s.rdata = 8'h00;

        // Wakeup flags: the set wins over a same-cycle clear by read.
        if (bus_req.rd && bus_req.addr == `CCPM_ADDR_PWR_DOWN) begin
            next_s.wake_flags = '0; // see [RULE16]
        end

        if (bus_req.rd) begin
            case (bus_req.addr)
                `CCPM_ADDR_CORE_CLK: next_s.rdata = s.core_ctl;
                `CCPM_ADDR_PWR_DOWN: next_s.rdata = {s.wake_flags, 2'h0, s.prev_mode}; // see [RULE15] [RULE19]
                `CCPM_ADDR_LF_CLK: next_s.rdata = {lf_level, lf_active, 2'h0, // see [RULE9] [RULE10]
                    s.core_ctl[`CCPM_CC_BYPASS] ? 1'b0 : (xo_run && s.start_active != `CCPM_START_RC), // see [RULE11]
                    s.lf_src};
                default: next_s.rdata = 8'h00;
            endcase
        end

        if (bus_req.wr) begin
            case (bus_req.addr)
                `CCPM_ADDR_CORE_CLK: next_s.core_ctl = bus_req.wdata;
                `CCPM_ADDR_LF_CLK: next_s.lf_src = bus_req.wdata[2:0]; // see [RULE12]
                `CCPM_ADDR_PWR_DOWN: begin
                    // Reserved codes are dropped so the running mode is left alone.
                    if (bus_req.wdata[2:0] != `CCPM_PD_RUN && !pd_reserved && s.state == CCPM_RUN) begin // see [RULE17] [RULE23]
                        next_s.mode = bus_req.wdata[2:0]; // see [RULE18]
                        next_s.state = CCPM_SLEEP;
                        next_s.wake_flags = '0; // see [RULE16]
                    end
                end
                default: ;
            endcase
        end

        case (s.state)
            CCPM_RUN: ;
            CCPM_SLEEP: begin
                if (wake_any) begin
                    next_s.wake_flags = s.wake_flags | wake_event;
                    next_s.prev_mode = s.mode; // see [RULE19]
                    // Start field takes effect only after a retention or deep sleep pass.
                    if (s.mode != `CCPM_PD_STBY && s.core_ctl[5:4] != 2'h3) begin
                        next_s.start_active = s.core_ctl[5:4]; // see [RULE4] [RULE23]
                    end
                    next_s.state = CCPM_WAIT_LF;
                end
            end
            CCPM_WAIT_LF: begin
                // No reset here: the processor resumes at its current instruction.
                if (s.lf_src == `CCPM_LF_NONE || lf_rdy) begin // see [RULE14] [RULE22]
                    next_s.state = CCPM_RUN;
                    next_s.mode = `CCPM_PD_RUN;
                end
            end
            default: next_s.state = CCPM_RUN;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s <= '0;
            s.state <= CCPM_WAIT_LF;
            s.core_ctl <= `CCPM_RST_CORE_CLK;
            s.lf_src <= `CCPM_RST_LF_SRC;
            s.prev_mode <= `CCPM_PD_RUN;
            s.start_active <= `CCPM_START_BOTH;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_comb begin
        logic deep;
        deep = (s.mode == `CCPM_PD_DEEP) || (s.mode == `CCPM_PD_MEM_OFF) || (s.mode == `CCPM_PD_MEM_ON);
        clk_ctl.fast_rc_en = (s.start_active != `CCPM_START_XO) && !deep; // see [RULE2]
        clk_ctl.fast_xo_en = (s.start_active != `CCPM_START_RC) && !deep // see [RULE2] [RULE13]
            && !(s.mode == `CCPM_PD_REG && !s.core_ctl[`CCPM_CC_KEEP_XO]); // see [RULE7]
        clk_ctl.core_from_xo = clk_ctl.fast_xo_en && xo_run; // see [RULE3]
        clk_ctl.core_from_pin = s.core_ctl[`CCPM_CC_BYPASS]; // see [RULE1]
        clk_ctl.core_div = s.core_ctl[2:0]; // see [RULE6]
        clk_ctl.core_clk_stop = (s.state != CCPM_RUN);
        // A synthesized source dies with the crystal in deep modes.
        clk_ctl.lf_src = (deep && s.lf_src == `CCPM_LF_SYNTH) ? `CCPM_LF_NONE : s.lf_src; // see [RULE13]
        clk_ctl.timers_on = lf_active && (s.mode != `CCPM_PD_MEM_OFF) && (s.mode != `CCPM_PD_DEEP); // see [RULE21]
    end

    assign bus_rdata = s.rdata;
    assign power_mode = s.mode;
    assign mcu_hold = (s.state != CCPM_RUN); // see [RULE14]
    assign crystal_ready_interrupt = s.xrdy_irq; // see [RULE5]
    assign crystal_ready_wakeup = s.xrdy_irq;
endmodule

// ==== core/ccpm_map.svh ====
// Register map, field positions, reset values and codes of the clock and power-mode control block.
`ifndef CCPM_MAP_SVH
`define CCPM_MAP_SVH
// Overview of operation
// [RULE1] Pin-bypass bit set: core clock taken straight from the crystal input pin.
// [RULE2] Start field: 00 both oscillators, 01 RC only, 10 crystal only, 11 reserved.
// [RULE3] With both started, run from RC first, then switch to crystal once running.
// [RULE4] A new start field value applies only after a retention or deep sleep pass.
// [RULE5] Crystal-ready enable set: crystal becoming active raises wakeup and interrupt.
// [RULE6] Divider field halves core clock per step, 16 MHz at 000 to 125 kHz at 111.
// [RULE7] Keep-crystal bit set: crystal keeps running in register retention.
// [RULE8] Software writes 00 to start field before register retention when keep-crystal set.
// [RULE9] Reading the phase bit returns the present low-frequency clock level.
// [RULE10] Ready bit reads 1 once the selected low-frequency clock is usable.
// [RULE11] Source status reads 1 when core clock comes from running crystal, else 0.
// [RULE12] Low-frequency source: crystal, RC, from fast crystal, analog pin, digital pin, none.
// [RULE13] Deep sleep and memory retention stop the crystal and any clock derived from it.
// [RULE14] With a low-frequency source selected, hold start or wakeup until it operates.
// [RULE15] Power-down register bits 7, 6, 5 flag pin, tick and comparator wakeups.
// [RULE16] Wakeup flags clear on read of their register and on power-down entry.
// [RULE17] Nonzero power-down write enters a power-saving mode; 000 keeps running.
// [RULE18] Codes: 001 deep sleep, 010/011 memory retention, 100 register retention, 111 standby.
// [RULE19] Reading the power-down field returns the previous mode, 000 power off.
// [RULE20] After wakeup software should write 0x00 to the power-down register.
// [RULE21] Register retention runs timers only when an active low-frequency source exists.
// [RULE22] Register retention wakeup resumes execution with no system reset.
// [RULE23] Reserved power-down or start codes change neither mode nor oscillators.

// ----------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------
`define CCPM_ADDR_CORE_CLK 8'ha3
`define CCPM_ADDR_PWR_DOWN 8'ha4
`define CCPM_ADDR_LF_CLK 8'had
`define CCPM_RST_CORE_CLK 8'h00
`define CCPM_RST_LF_SRC 3'h0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CCPM_CC_KEEP_XO 7
`define CCPM_CC_BYPASS 6
`define CCPM_CC_START_HI 5
`define CCPM_CC_START_LO 4
`define CCPM_CC_XRDY_EN 3
`define CCPM_PD_WAKE_PIN 7
`define CCPM_PD_WAKE_TICK 6
`define CCPM_PD_WAKE_COMP 5
`define CCPM_LF_PHASE 7
`define CCPM_LF_READY 6
`define CCPM_LF_XO_SRC 3

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define CCPM_START_BOTH 2'h0
`define CCPM_START_RC 2'h1
`define CCPM_START_XO 2'h2
`define CCPM_PD_RUN 3'h0
`define CCPM_PD_DEEP 3'h1
`define CCPM_PD_MEM_OFF 3'h2
`define CCPM_PD_MEM_ON 3'h3
`define CCPM_PD_REG 3'h4
`define CCPM_PD_STBY 3'h7
`define CCPM_LF_XO32 3'h0
`define CCPM_LF_RC32 3'h1
`define CCPM_LF_SYNTH 3'h2
`define CCPM_LF_PIN_ANA 3'h3
`define CCPM_LF_PIN_DIG 3'h4
`define CCPM_LF_NONE 3'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CCPM_CLK_MHZ 25
`define CCPM_PHASE_CYCLES 1
`endif

// ==== core/ccpm_pkg.sv ====
// Types shared by the clock and power-mode control block.
package ccpm_pkg;
    typedef enum logic [2:0] {
        CCPM_RUN,
        CCPM_SLEEP,
        CCPM_WAIT_LF
    } ccpm_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ccpm_bus_req_t;

    typedef struct packed {
        logic pin;
        logic tick;
        logic comp;
    } ccpm_wake_t;

    typedef struct packed {
        logic fast_xo_en;
        logic fast_rc_en;
        logic core_from_xo;
        logic core_from_pin;
        logic [2:0] core_div;
        logic core_clk_stop;
        logic [2:0] lf_src;
        logic timers_on;
    } ccpm_clk_ctl_t;

    typedef struct packed {
        ccpm_state_t state;
        logic [2:0] mode;
        logic [2:0] prev_mode;
        logic [7:0] core_ctl;
        logic [1:0] start_active;
        logic [2:0] lf_src;
        ccpm_wake_t wake_flags;
        logic xo_seen;
        logic xrdy_irq;
        logic [7:0] rdata;
        logic [2:0] xo_sync;
        logic [2:0] lf_sync;
        logic [2:0] lfr_sync;
    } ccpm_state_rec_t;
endpackage

// ==== verification/ccpm_core_properties.sv ====
// Port-level assertions for the clock and power-mode control block.
`timescale 1ns/100ps
module ccpm_checker (
    // Clock, reset and register port
    input logic clk_sys,
    input logic reset,
    input ccpm_pkg::ccpm_bus_req_t bus_req,
    input logic [7:0] bus_rdata,
    // Status and controls
    input logic low_freq_ready,
    input ccpm_pkg::ccpm_clk_ctl_t clk_ctl,
    input logic [2:0] power_mode,
    input logic mcu_hold,
    input logic crystal_ready_interrupt,
    input logic crystal_ready_wakeup
);
    import ccpm_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    chk_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
        else $error("read data outside the read slot");
    chk_bypass_pin: assert property (bus_req.wr && bus_req.addr == 8'ha3
        |=> clk_ctl.core_from_pin == $past(bus_req.wdata[6])) else $error("bypass bit not applied");
    chk_div_code: assert property (bus_req.wr && bus_req.addr == 8'ha3
        |=> clk_ctl.core_div == $past(bus_req.wdata[2:0])) else $error("divider not applied");
    chk_pd_enter: assert property (bus_req.wr && bus_req.addr == 8'ha4 && power_mode == 3'h0 && !mcu_hold
        && bus_req.wdata[2:0] inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h7}
        |=> power_mode == $past(bus_req.wdata[2:0]) && mcu_hold) else $error("mode not entered");
    chk_pd_reserved: assert property (bus_req.wr && bus_req.addr == 8'ha4 && power_mode == 3'h0
        && bus_req.wdata[2:0] inside {3'h0, 3'h5, 3'h6} |=> power_mode == 3'h0) else $error("reserved code acted");
    chk_irq_pulse: assert property (crystal_ready_interrupt |=> !crystal_ready_interrupt)
        else $error("interrupt longer than one cycle");
    chk_irq_pair: assert property (crystal_ready_interrupt == crystal_ready_wakeup)
        else $error("wakeup and interrupt differ");
    chk_xo_stop: assert property (power_mode inside {3'h1, 3'h2, 3'h3} |-> !clk_ctl.fast_xo_en)
        else $error("crystal runs in deep mode");
    chk_synth_stop: assert property (power_mode inside {3'h1, 3'h2, 3'h3} |-> clk_ctl.lf_src != 3'h2)
        else $error("synthesized slow clock runs in deep mode");
    chk_stby_stop: assert property (power_mode == 3'h7 |-> clk_ctl.core_clk_stop)
        else $error("core clock runs in standby");
    chk_timers_lf: assert property (power_mode == 3'h4 |-> clk_ctl.timers_on == (clk_ctl.lf_src != 3'h7))
        else $error("timers wrong in retention");
    chk_hold_lf: assert property ($fell(mcu_hold) && clk_ctl.lf_src != 3'h7 |-> $past(low_freq_ready, 3))
        else $error("released before slow clock ready");
endmodule
bind ccpm_core ccpm_checker u_chk (
    .clk_sys(clk_sys),
    .reset(reset),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .low_freq_ready(low_freq_ready),
    .clk_ctl(clk_ctl),
    .power_mode(power_mode),
    .mcu_hold(mcu_hold),
    .crystal_ready_interrupt(crystal_ready_interrupt),
    .crystal_ready_wakeup(crystal_ready_wakeup)
);

// ==== verification/ccpm_core_test.sv ====
// Self-checking bench for the clock and power-mode control block.
`timescale 1ns/100ps
module ccpm_core_test;
    import ccpm_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    ccpm_bus_req_t bus_req = '0;
    logic [7:0] bus_rdata;
    logic fast_xo_running = 1'b0;
    logic low_freq_clock = 1'b0;
    logic low_freq_ready = 1'b1;
    ccpm_wake_t wake_event = '0;
    ccpm_clk_ctl_t clk_ctl;
    logic [2:0] power_mode;
    logic mcu_hold, crystal_ready_interrupt, crystal_ready_wakeup;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    ccpm_core u_dut (
        .clk_sys(clk_sys),
        .reset(reset),
        .bus_req(bus_req),
        .bus_rdata(bus_rdata),
        .fast_xo_running(fast_xo_running),
        .low_freq_clock(low_freq_clock),
        .low_freq_ready(low_freq_ready),
        .wake_event(wake_event),
        .clk_ctl(clk_ctl),
        .power_mode(power_mode),
        .mcu_hold(mcu_hold),
        .crystal_ready_interrupt(crystal_ready_interrupt),
        .crystal_ready_wakeup(crystal_ready_wakeup)
    );
    initial forever #20 clk_sys = ~clk_sys;
    // ------------------------------------------------------------
    // Bus tasks and checks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_req <= {a, d, 2'b10};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken mid-cycle, clear of both edges.
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
        bus_req <= {a, 8'h00, 2'b01};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        @(negedge clk_sys);
        chk(n, e, bus_rdata & m);
        @(posedge clk_sys);
    endtask
    task automatic wake(input logic [2:0] w);
        wake_event <= w;
        @(posedge clk_sys);
        wake_event <= 3'h0;
        repeat (20) if (mcu_hold !== 1'b0) @(posedge clk_sys);
        chk("awake", 8'h00, {7'h0, mcu_hold});
    endtask
    task automatic t_regs;
        rd(8'ha3, 8'hff, 8'h00, "core reset");
        rd(8'had, 8'hff, 8'h40, "lf reset");
        wr(8'ha5, 8'hff);
        rd(8'ha3, 8'hff, 8'h00, "core kept");
        for (int d = 0; d < 8; d++) begin
            wr(8'ha3, 8'h40 | 8'(d));
            chk("div", 8'(d), {5'h0, clk_ctl.core_div});
            chk("pin", 8'h01, {7'h0, clk_ctl.core_from_pin});
        end
        rd(8'ha3, 8'hff, 8'h47, "core read");
    endtask
    task automatic t_lf;
        logic [2:0] src [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
        foreach (src[i]) begin
            wr(8'had, {5'h0, src[i]});
            rd(8'had, 8'h47, {1'b0, src[i] != 3'h7, 3'h0, src[i]}, "lf src");
        end
        wr(8'had, 8'h00);
        low_freq_clock <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rd(8'had, 8'h80, 8'h80, "phase");
        low_freq_clock <= 1'b0;
    endtask
    task automatic t_xo;
        int n;
        chk("from xo", 8'h00, {7'h0, clk_ctl.core_from_xo});
        for (int en = 0; en < 2; en++) begin
            n = 0;
            wr(8'ha3, 8'(en << 3));
            fast_xo_running <= 1'b1;
            repeat (10) begin
                @(posedge clk_sys);
                if (crystal_ready_interrupt === 1'b1) n++;
            end
            chk("xo irq", 8'(en), 8'(n));
            fast_xo_running <= 1'b0;
            repeat (6) @(posedge clk_sys);
        end
        fast_xo_running <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk("from xo", 8'h01, {7'h0, clk_ctl.core_from_xo});
        rd(8'had, 8'h08, 8'h08, "xo status");
    endtask
    task automatic t_sleep;
        logic [2:0] md [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
        logic [2:0] wk [5] = '{3'h4, 3'h2, 3'h1, 3'h2, 3'h4};
        wr(8'ha3, 8'h88);
        foreach (md[i]) begin
            wake_event <= 3'h7;
            @(posedge clk_sys);
            wake_event <= 3'h0;
            wr(8'ha4, {5'h0, md[i]});
            chk("mode", {5'h0, md[i]}, {5'h0, power_mode});
            chk("xo en", {7'h0, md[i] > 3'h3}, {7'h0, clk_ctl.fast_xo_en});
            wake(wk[i]);
            rd(8'ha4, 8'he7, {wk[i], 2'h0, md[i]}, "flags");
            rd(8'ha4, 8'he0, 8'h00, "cleared");
            wr(8'ha4, 8'h00);
        end
    endtask
    task automatic t_start;
        logic [1:0] st [3] = '{2'h3, 2'h1, 2'h2};
        logic [1:0] was = 2'h3;
        foreach (st[i]) begin
            wr(8'ha3, {2'h0, st[i], 4'h0});
            chk("held", {6'h0, was}, {6'h0, clk_ctl.fast_xo_en, clk_ctl.fast_rc_en});
            wr(8'ha4, 8'h01);
            wake(3'h4);
            chk("applied", {6'h0, st[i]}, {6'h0, clk_ctl.fast_xo_en, clk_ctl.fast_rc_en});
            was = st[i];
        end
        for (int c = 5; c < 7; c++) begin
            wr(8'ha4, 8'(c));
            chk("reserved", 8'h00, {4'h0, mcu_hold, power_mode});
        end
    endtask
    // A synthesized slow clock that is not ready must keep the processor held after a wakeup.
    task automatic t_hold;
        low_freq_ready <= 1'b0;
        wr(8'had, 8'h02);
        repeat (3) @(posedge clk_sys);
        rd(8'had, 8'h47, 8'h02, "lf not ready");
        wr(8'ha4, 8'h02);
        chk("synth off", 8'h07, {5'h0, clk_ctl.lf_src});
        wake_event <= 3'h2;
        @(posedge clk_sys);
        wake_event <= 3'h0;
        repeat (10) @(posedge clk_sys);
        chk("lf held", 8'h01, {7'h0, mcu_hold});
        low_freq_ready <= 1'b1;
        wake(3'h0);
        rd(8'ha4, 8'he7, 8'h42, "hold flags");
        wr(8'ha4, 8'h00);
        wr(8'had, 8'h00);
    endtask
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (6) @(posedge clk_sys);
        t_regs();
        t_lf();
        t_xo();
        t_sleep();
        t_start();
        t_hold();
        wrap_up();
    end
endmodule
